/* File: verilog/adc_seq_defines.svh */
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Bus clock period and the worst-case startup of the dedicated clock.
`define CLK_PERIOD_NS 8
`define ASYNC_STARTUP_NS 5000
`define ASYNC_STARTUP_CYC (`ASYNC_STARTUP_NS / `CLK_PERIOD_NS)

// Conversion-clock counts of a single or first continuous conversion.
`define TICKS_8BIT_SHORT 6'h12
`define TICKS_8BIT_LONG 6'h26
`define TICKS_10BIT_SHORT 6'h15
`define TICKS_10BIT_LONG 6'h29
// Later continuous conversions skip the first-conversion setup ticks.
`define TICKS_CONT_SAVING 6'h02

// Sample window in conversion-clock ticks: 3.5 and 23.5 rounded up.
`define SAMPLE_TICKS_SHORT 6'h04
`define SAMPLE_TICKS_LONG 6'h18

// Bus cycles spent synchronising the start request; one more transfers.
`define SYNC_BUS_CYC 2'h2

// Channel code that selects no input and starts nothing.
`define CHANNEL_OFF 5'h1F

// Result reset values.
`define RESULT_RESET 10'h000

`endif

/* File: verilog/adc_seq_pkg.sv */
package adc_seq_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WARMUP = 3'b001,
		ST_SYNC = 3'b010,
		ST_CONVERT = 3'b011,
		ST_TRANSFER = 3'b100
	} seq_state_t;

	typedef enum logic [1:0] {
		SRC_ALT = 2'b00,
		SRC_BUS = 2'b01,
		SRC_ASYNC = 2'b10
	} clk_src_t;

endpackage : adc_seq_pkg

/* File: verilog/conv_clock_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Links the sequencer to the conversion clock generator.
interface conv_clock_if;
	import adc_seq_pkg::*;
	logic run;
	clk_src_t src;
	logic [1:0] divide;
	logic tick;

	modport gen (input run, input src, input divide, output tick);
	modport use_side (output run, output src, output divide, input tick);
endinterface : conv_clock_if

`default_nettype wire

/* File: verilog/conv_clock_gen.sv */
`timescale 1ns/100ps
`default_nettype none

module conv_clock_gen (
	input wire logic clk_i, // Bus clock.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic async_clk_i, // Dedicated asynchronous clock level.
	input wire logic alt_clk_i, // Alternate clock level.
	conv_clock_if.gen cc // Run, source, divide and tick.
);
	import adc_seq_pkg::*;

	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic level_a;
	logic level_b;
	logic [2:0] cnt;
	logic next_level_a;
	logic next_level_b;
	logic [2:0] next_cnt;
	logic next_tick;
	logic edge_a;
	logic edge_b;
	logic src_edge;
	logic [2:0] last;

	// Source edges, divide ratio, and the gated tick.
	always_comb
	begin
		next_level_a = level_a;
		next_level_b = level_b;
		if (sync_a[1] == sync_a[2])
			next_level_a = sync_a[2];
		if (sync_b[1] == sync_b[2])
			next_level_b = sync_b[2];
		edge_a = next_level_a & ~level_a;
		edge_b = next_level_b & ~level_b;
		unique case (cc.src)
			SRC_ASYNC: src_edge = edge_a;
			SRC_BUS: src_edge = 1'b1;
			default: src_edge = edge_b;
		endcase
		last = 3'(({2'h0, 1'b1} << cc.divide) - 3'h1);
		next_cnt = cnt;
		next_tick = 1'b0;
		if (!cc.run)
			next_cnt = 3'h0; // Clocks stop while the converter idles.
		else if (src_edge)
		begin
			if (cnt == last)
			begin
				next_cnt = 3'h0;
				next_tick = 1'b1;
			end
			else
				next_cnt = cnt + 3'h1;
		end
	end

	// Synchronisers and divider registers.
	always_ff @(posedge clk_i)
	begin
		sync_a <= {sync_a[1:0], async_clk_i};
		sync_b <= {sync_b[1:0], alt_clk_i};
		if (rst_i)
		begin
			level_a <= 1'b0;
			level_b <= 1'b0;
			cnt <= 3'h0;
			cc.tick <= 1'b0;
		end
		else
		begin
			level_a <= next_level_a;
			level_b <= next_level_b;
			cnt <= next_cnt;
			cc.tick <= next_tick;
		end
	end

endmodule : conv_clock_gen

`default_nettype wire

/* File: verilog/adc_conversion_sequencer.sv */
// How it works
// - Status/control write aborts and restarts unless channel code is all ones.
// - Clock configuration write aborts any running conversion.
// - Stop entry without the asynchronous clock aborts the conversion.
// - Non-reset abort leaves both result registers at the last good result.
// - Reset aborts and returns result registers to reset values.
// - Any abort or reset powers down at once and goes idle, except a restarting status write.
// - 8-bit short sample: first 18 ticks plus 3 bus cycles, later 16.
// - 8-bit long sample: first 38 ticks plus 3 bus cycles, later 36.
// - 10-bit short sample: first 21 ticks plus 3 bus cycles, later 19.
// - 10-bit long sample: first 41 ticks plus 3 bus cycles, later 39.
// - Asynchronous clock adds up to 5 us startup to a first conversion.
// - Sample phase is 3.5 ticks, or 23.5 with long sampling.
// - Conversion clock is the selected source divided by the set ratio.
// - Approximation is rounded to 8 or 10 bits, saturating at full scale.
// - Source: asynchronous if enabled, else alternate or bus per select bit.
// - Divide ratio is 1, 2, 4 or 8.
// - Completion loads results, sets complete flag, interrupts if enabled.
// - Continuous mode restarts after every transfer until aborted.
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_defines.svh"

module adc_conversion_sequencer (
	input wire logic clk_i, // Bus clock, 125 MHz.
	input wire logic rst_i, // Synchronous reset, active high.
	input wire logic status_write_i, // Status/control register write strobe.
	input wire logic [4:0] channel_select_i, // Channel code written.
	input wire logic continuous_enable_i, // Continuous mode written.
	input wire logic complete_irq_enable_i, // Interrupt enable written.
	input wire logic mode_10bit_i, // Resolution written: 1 is 10-bit.
	input wire logic long_sample_select_i, // Long sample written.
	input wire logic clock_write_i, // Clock configuration write strobe.
	input wire logic async_clock_enable_i, // Asynchronous clock enable written.
	input wire logic input_clock_select_i, // Bus clock select written.
	input wire logic [1:0] clock_divide_select_i, // Divide ratio code written.
	input wire logic stop_mode_i, // Device is entering stop mode.
	input wire logic async_clk_i, // Dedicated asynchronous clock.
	input wire logic alt_clk_i, // Alternate clock.
	input wire logic [10:0] approx_i, // Approximation with one guard bit.
	output logic [1:0] result_high_reg_o, // Result high register.
	output logic [7:0] result_low_reg_o, // Result low register.
	output logic conversion_complete_flag_o, // Completion flag.
	output logic irq_o, // Completion interrupt request.
	output logic [4:0] channel_o, // Channel under conversion.
	output logic sampling_o, // Sample switch closed.
	output logic power_on_o // Clocks and references enabled.
);
	import adc_seq_pkg::*;

	conv_clock_if cc ();

	seq_state_t state;
	seq_state_t next_state;
	logic [9:0] result;
	logic [9:0] next_result;
	logic conversion_complete_flag;
	logic next_conversion_complete_flag;
	logic [5:0] ticks;
	logic [5:0] next_ticks;
	logic [5:0] target;
	logic [5:0] next_target;
	logic [9:0] wait_cnt;
	logic [9:0] next_wait_cnt;
	logic [10:0] approx_q;
	logic [10:0] next_approx_q;
	logic [4:0] channel;
	logic cont_en;
	logic irq_en;
	logic ten_bit;
	logic long_smp;
	logic async_en;
	logic clk_sel;
	logic [1:0] divide;
	logic abort;
	logic start;
	logic [5:0] base;

	// Rounds the guard-bit approximation to the chosen width, saturating.
	function automatic logic [9:0] round_code(input logic [10:0] a, input logic ten);
		logic [10:0] s10;
		logic [8:0] s8;
		s10 = {1'b0, a[10:1]} + {10'h000, a[0]};
		s8 = {1'b0, a[10:3]} + {8'h00, a[2]};
		if (ten)
			round_code = s10[10] ? 10'h3FF : s10[9:0];
		else
			round_code = s8[8] ? 10'h0FF : {2'h0, s8[7:0]};
	endfunction : round_code

	conv_clock_gen u_clk (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_clk_i(async_clk_i),
		.alt_clk_i(alt_clk_i),
		.cc(cc)
	);

	// Abort sources and the software start.
	assign abort = status_write_i | clock_write_i
		| (stop_mode_i & ~async_en);
	assign start = status_write_i & (channel_select_i != `CHANNEL_OFF);
	assign base = ten_bit ? (long_smp ? `TICKS_10BIT_LONG : `TICKS_10BIT_SHORT)
		: (long_smp ? `TICKS_8BIT_LONG : `TICKS_8BIT_SHORT);

	// Conversion clock control.
	assign cc.run = (state == ST_CONVERT) & ~abort;
	assign cc.src = async_en ? SRC_ASYNC : (clk_sel ? SRC_BUS : SRC_ALT);
	assign cc.divide = divide;

	// Ports; power drops in the same cycle as an abort.
	assign power_on_o = (state != ST_IDLE) & ~abort & ~rst_i;
	assign sampling_o = (state == ST_CONVERT) & ~abort
		& (ticks < (long_smp ? `SAMPLE_TICKS_LONG : `SAMPLE_TICKS_SHORT));
	assign irq_o = conversion_complete_flag & irq_en;
	assign result_high_reg_o = result[9:8];
	assign result_low_reg_o = result[7:0];
	assign conversion_complete_flag_o = conversion_complete_flag;
	assign channel_o = channel;

	// Sequencer next-state logic.
	always_comb
	begin
		next_state = state;
		next_result = result;
		next_conversion_complete_flag = conversion_complete_flag;
		next_ticks = ticks;
		next_target = target;
		next_wait_cnt = wait_cnt;
		next_approx_q = approx_q;
		if (status_write_i)
			next_conversion_complete_flag = 1'b0;
		if (abort)
		begin
			next_state = ST_IDLE;
			next_wait_cnt = 10'h000;
			if (start)
				next_state = async_en ? ST_WARMUP : ST_SYNC;
		end
		else
		begin
			unique case (state)
				ST_IDLE: ;
				ST_WARMUP:
				begin
					next_wait_cnt = wait_cnt + 10'h001;
					if (wait_cnt == 10'(`ASYNC_STARTUP_CYC - 1))
					begin
						next_wait_cnt = 10'h000;
						next_state = ST_SYNC;
					end
				end
				ST_SYNC:
				begin
					next_wait_cnt = wait_cnt + 10'h001;
					next_ticks = 6'h00;
					next_target = base;
					if (wait_cnt == 10'(`SYNC_BUS_CYC - 2'h1))
					begin
						next_wait_cnt = 10'h000;
						next_state = ST_CONVERT;
					end
				end
				ST_CONVERT:
				begin
					if (cc.tick)
					begin
						next_ticks = ticks + 6'h01;
						if (ticks + 6'h01 == target)
						begin
							next_approx_q = approx_i;
							next_state = ST_TRANSFER;
						end
					end
				end
				ST_TRANSFER:
				begin
					next_result = round_code(approx_q, ten_bit);
					next_conversion_complete_flag = 1'b1;
					next_ticks = 6'h00;
					next_target = base - `TICKS_CONT_SAVING;
					next_state = cont_en ? ST_CONVERT : ST_IDLE;
				end
			endcase
		end
	end

	// Sequencer and configuration registers.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= ST_IDLE;
			result <= `RESULT_RESET;
			conversion_complete_flag <= 1'b0;
			ticks <= 6'h00;
			target <= 6'h00;
			wait_cnt <= 10'h000;
			approx_q <= 11'h000;
			channel <= `CHANNEL_OFF;
			cont_en <= 1'b0;
			irq_en <= 1'b0;
			ten_bit <= 1'b0;
			long_smp <= 1'b0;
			async_en <= 1'b0;
			clk_sel <= 1'b0;
			divide <= 2'h0;
		end
		else
		begin
			state <= next_state;
			result <= next_result;
			conversion_complete_flag <= next_conversion_complete_flag;
			ticks <= next_ticks;
			target <= next_target;
			wait_cnt <= next_wait_cnt;
			approx_q <= next_approx_q;
			if (status_write_i)
			begin
				channel <= channel_select_i;
				cont_en <= continuous_enable_i;
				irq_en <= complete_irq_enable_i;
				ten_bit <= mode_10bit_i;
				long_smp <= long_sample_select_i;
			end
			if (clock_write_i)
			begin
				async_en <= async_clock_enable_i;
				clk_sel <= input_clock_select_i;
				divide <= clock_divide_select_i;
			end
		end
	end

	// Checks on the sequencer.
	AST_RESTART: assert property (@(posedge clk_i) disable iff (rst_i)
		start |=> (state == ST_WARMUP || state == ST_SYNC))
		else $error("Start write did not restart the sequence.");
	AST_CLK_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
		clock_write_i && !status_write_i |=> state == ST_IDLE)
		else $error("Clock write did not abort.");
	AST_STOP_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
		stop_mode_i && !async_en && !status_write_i |=> state == ST_IDLE)
		else $error("Stop entry did not abort.");
	AST_KEEP_RESULT: assert property (@(posedge clk_i) disable iff (rst_i)
		abort |=> $stable(result) && !$rose(conversion_complete_flag))
		else $error("Abort disturbed the results.");
	AST_RESET_RESULT: assert property (@(posedge clk_i)
		rst_i |=> result == `RESULT_RESET && state == ST_IDLE)
		else $error("Reset did not clear the results.");
	AST_POWER_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		abort |-> !power_on_o && !sampling_o)
		else $error("Power stayed on during an abort.");
	AST_TICK_COUNT: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_TRANSFER |-> ticks == target
		&& (target == base || target == base - `TICKS_CONT_SAVING))
		else $error("Conversion tick count wrong.");
	AST_WARMUP_BOUND: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_WARMUP |-> wait_cnt < 10'(`ASYNC_STARTUP_CYC))
		else $error("Startup wait overran.");
	AST_SYNC_LEN: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_SYNC && $past(state) != ST_SYNC && !abort ##1 !abort
		|=> state == ST_CONVERT)
		else $error("Start synchronisation length wrong.");
	AST_COMPLETE: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_TRANSFER && !abort |=> conversion_complete_flag && result == round_code($past(approx_q), ten_bit))
		else $error("Completion did not load result and flag.");
	AST_CONTINUE: assert property (@(posedge clk_i) disable iff (rst_i)
		state == ST_TRANSFER && !abort && cont_en |=> state == ST_CONVERT && ticks == 6'h00)
		else $error("Continuous mode did not restart.");

endmodule : adc_conversion_sequencer

`default_nettype wire

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic clk, rst, sw, cw, cont, ie, m10, ls, ae, ics, stp, aclk, bclk;
	logic [4:0] ch;
	logic [4:0] cho;
	logic [1:0] dv;
	logic [10:0] ap;
	logic [1:0] rh;
	logic [7:0] rl;
	logic flag, irq, smp, pwr;
	logic [31:0] seed = 32'h9E63;
	logic [9:0] keep;
	logic [9:0] expq[$];
	int tk[4] = '{18, 38, 21, 41};
	int err_total = 0;
	int compares = 0;
	int n, r, i, w;
	logic p;

	adc_conversion_sequencer u_adc_conversion_sequencer (
		.clk_i(clk), .rst_i(rst), .status_write_i(sw), .channel_select_i(ch),
		.continuous_enable_i(cont), .complete_irq_enable_i(ie), .mode_10bit_i(m10),
		.long_sample_select_i(ls), .clock_write_i(cw), .async_clock_enable_i(ae),
		.input_clock_select_i(ics), .clock_divide_select_i(dv), .stop_mode_i(stp),
		.async_clk_i(aclk), .alt_clk_i(bclk), .approx_i(ap), .result_high_reg_o(rh),
		.result_low_reg_o(rl), .conversion_complete_flag_o(flag), .irq_o(irq),
		.channel_o(cho), .sampling_o(smp), .power_on_o(pwr)
	);

	// Bus clock, dedicated clock of 512 ns and alternate clock of 32 ns.
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		aclk = 1'b0;
		forever #256 aclk = ~aclk;
	end
	initial
	begin
		bclk = 1'b0;
		forever #16 bclk = ~bclk;
	end

	// Pseudo-random source for samples, channels and enables.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Reference rounding of the approximation, saturating at full scale.
	function automatic logic [9:0] model(input logic [10:0] a, input logic b10);
		if (b10)
			model = (a[10:1] == 10'h3FF) ? 10'h3FF : a[10:1] + {9'h000, a[0]};
		else
			model = (a[10:3] == 8'hFF) ? 10'h0FF : {2'h0, a[10:3] + {7'h00, a[2]}};
	endfunction : model

	// Compares a value and counts the outcome.
	task automatic chk_val(input string nm, input logic [9:0] e, input logic [9:0] g);
		compares++;
		if (g !== e)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val

	// Checks that a cycle count lies inside its window.
	task automatic chk_time(input string nm, input int lo, input int hi, input int g);
		compares++;
		if (g < lo || g > hi)
		begin
			err_total++;
			$display("wrong value %s expected %0d to %0d seen %0d", nm, lo, hi, g);
		end
	endtask : chk_time

	// One status write; the converter must power down while it is taken.
	task automatic wr_st(input logic [4:0] c, input logic co);
		@(posedge clk);
		sw <= 1'b1;
		ch <= c;
		cont <= co;
		@(negedge clk);
		chk_val("power_on", 10'h000, {9'h000, pwr});
		@(posedge clk);
		sw <= 1'b0;
	endtask : wr_st

	// One clock configuration write.
	task automatic wr_clk(input logic a, input logic s, input logic [1:0] d);
		@(posedge clk);
		cw <= 1'b1;
		ae <= a;
		ics <= s;
		dv <= d;
		@(posedge clk);
		cw <= 1'b0;
	endtask : wr_clk

	// Single conversion: latency, rounded result, interrupt and channel.
	task automatic conv(input logic b10, input logic l, input int per, input int extra);
		logic [4:0] c;
		seed = lfsr(seed);
		c = {1'b0, seed[15:12]};
		@(posedge clk);
		ap <= seed[10:0];
		m10 <= b10;
		ls <= l;
		ie <= seed[11];
		expq.push_back(model(seed[10:0], b10));
		wr_st(c, 1'b0);
		n = 0;
		// The flag is first looked at on a falling edge, after the write has cleared it.
		do
		begin
			@(negedge clk);
			n++;
		end
		while (flag !== 1'b1 && n < 6000);
		chk_time("latency", tk[{b10, l}] * per, tk[{b10, l}] * per + per + 8 + extra, n);
		chk_val("result", expq.pop_front(), {rh, rl});
		chk_val("irq", {9'h000, seed[11]}, {9'h000, irq});
		chk_val("channel", {5'h00, c}, {5'h00, cho});
	endtask : conv

	// After an abort nothing completes and the last result stays.
	task automatic expect_abort(input logic [9:0] k);
		repeat (60) @(negedge clk);
		chk_val("power_on", 10'h000, {9'h000, pwr});
		chk_val("flag", 10'h000, {9'h000, flag});
		chk_val("held result", k, {rh, rl});
	endtask : expect_abort

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict

	// Cuts a hang short.
	initial
	begin
		#(80000 * 8);
		err_total++;
		$display("watchdog expired");
		give_verdict();
	end

	// Main sequence.
	initial
	begin
		{rst, sw, cw, cont, ie, m10, ls, ae, ics, stp, dv, ap} = '0;
		rst = 1'b1;
		ch = 5'h1F;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk_val("reset result", 10'h000, {rh, rl});
		chk_val("reset flags", 10'h000, {6'h00, flag, irq, smp, pwr});
		chk_val("reset channel", 10'h01F, {5'h00, cho});
		$display("test reset values done");
		wr_clk(1'b0, 1'b1, 2'h0);
		for (i = 0; i < 4; i++)
			conv(i[1], i[0], 1, 0);
		for (i = 1; i < 4; i++)
		begin
			wr_clk(1'b0, 1'b1, i[1:0]);
			conv(1'b1, 1'b0, 1 << i, 0);
		end
		wr_clk(1'b0, 1'b0, 2'h1);
		conv(1'b0, 1'b0, 8, 0);
		$display("test timing and sources done");
		wr_clk(1'b0, 1'b1, 2'h0);
		wr_st(5'h05, 1'b0);
		repeat (5) @(posedge clk);
		conv(1'b1, 1'b1, 1, 0);
		for (i = 0; i < 3; i++)
		begin
			wr_st(5'h02, 1'b0);
			keep = {rh, rl};
			repeat (10) @(posedge clk);
			if (i == 0)
				wr_st(5'h1F, 1'b0);
			else if (i == 1)
				wr_clk(1'b0, 1'b1, 2'h0);
			else
			begin
				stp <= 1'b1;
				@(posedge clk);
				stp <= 1'b0;
			end
			expect_abort(keep);
		end
		$display("test aborts done");
		m10 <= 1'b1;
		ls <= 1'b0;
		wr_st(5'h04, 1'b1);
		p = 1'b0;
		n = 0;
		r = 0;
		while (r < 3 && n < 3000)
		begin
			@(negedge clk);
			n++;
			if (smp === 1'b1 && p === 1'b0)
			begin
				// The first interval spans the first conversion, the later ones the shorter count.
				if (r > 0)
				begin
					chk_time("interval", (r == 1) ? 21 : 19, (r == 1) ? 30 : 22, n);
					chk_time("sample width", 4, 5, w);
				end
				r++;
				n = 0;
				w = 0;
			end
			if (smp === 1'b1)
				w++;
			p = smp;
		end
		chk_time("restarts", 3, 3, r);
		keep = {rh, rl};
		chk_val("cont result", model(ap, 1'b1), keep);
		wr_st(5'h1F, 1'b0);
		expect_abort(keep);
		$display("test continuous done");
		wr_clk(1'b1, 1'b0, 2'h0);
		@(posedge clk);
		stp <= 1'b1;
		conv(1'b0, 1'b0, 64, 625);
		@(posedge clk);
		stp <= 1'b0;
		$display("test dedicated clock in stop done");
		wr_clk(1'b0, 1'b1, 2'h0);
		wr_st(5'h06, 1'b0);
		repeat (10) @(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		chk_val("reset result", 10'h000, {rh, rl});
		chk_val("reset flags", 10'h000, {7'h00, flag, irq, pwr});
		@(posedge clk);
		rst <= 1'b0;
		$display("test reset abort done");
		give_verdict();
	end
endmodule : tb_top

`default_nettype wire
